// ---- verilog/exc_entry_seq.sv ----
// Purpose: exception entry for float-unavailable, system call, timers and tlb misses
// Assumes: pipeline presents events one cycle wide, synchronous to pclk
// Notes: priority among classes is resolved outside; higher_pending defers entry
// What this block does
// - take an interrupt only when no higher-priority exception is present
// - float instruction with float available clear raises float unavailable
// - noncritical entry copies whole machine state into save machine state
// - noncritical entry clears listed machine-state bits, keeps ce me de ri
// - handler address is prefix 0-15, offset 16-27, four zero bits
// - system call saves address of following instruction, taken on execution
// - system call syndrome keeps only the varlen flag, others cleared
// - auxiliary processor unavailable slot is never raised
// - decrementer taken when status, enable and external enable all one
// - timer entries save the address of the next instruction
// - fixed-interval status set on a selected time base bit rising
// - fixed-interval taken when status, enable and external enable all one
// - first watchdog time-out sets watchdog status, whether or not the watchdog enable is set
// - watchdog taken when status, enable and critical enable all one
// - watchdog entry is critical, uses critical save pair, clears ce
// - watchdog clears debug enable unless debug unit on and config bit off
// - data tlb miss raises entry, saves faulting load or store address
// - data tlb entry loads fault address and store, vector, varlen flags
// - instruction tlb miss raises entry, saves faulting instruction address
// - instruction tlb syndrome keeps only misaligned fetch flag
`timescale 1ns/1ps
module exc_entry_seq
	import exc_entry_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire pipe_event_t pipe_event,
	input wire logic higher_pending,
	input wire logic [63:0] time_base,
	input wire logic watchdog_timeout,
	input wire logic decrementer_expired,
	output entry_report_t entry
);
	logic [31:0] save_return_addr;
	logic [31:0] save_machine_state;
	logic [31:0] crit_save_return_addr;
	logic [31:0] crit_save_machine_state;
	logic [31:0] machine_state_reg;
	logic [31:0] exception_syndrome;
	logic [31:0] machine_check_syndrome;
	logic [31:0] data_fault_address;
	logic [31:0] vector_prefix;
	logic [31:0] timer_status;
	logic [31:0] timer_control;
	logic [31:0] impl_config_reg;
	logic [31:0] vector_offset [num_offsets];
	logic fit_bit_prev;
	logic watchdog_fired;

	// register bus decode
	wire logic rd_valid = paddr[1:0] == 2'h0;
	// misaligned writes are refused, otherwise the offset bank would alias them
	wire logic wr_access = psel & penable & pwrite & clk_en & rd_valid;
	wire logic in_offset_bank = paddr[11:5] == off_vector_offset_base[11:5];
	wire logic [2:0] offset_index = paddr[4:2];
	wire logic [31:0] wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
	wire logic hit_tsr = paddr == off_timer_status;
	wire logic hit_tcr = paddr == off_timer_control;
	wire logic hit_msr = paddr == off_machine_state_reg;
	wire logic hit_vector_prefix = paddr == off_vector_prefix;
	wire logic hit_hid = paddr == off_impl_config_reg;
	wire logic hit_save_return_addr = paddr == off_save_return_addr;
	wire logic hit_save_machine_state = paddr == off_save_machine_state;
	wire logic hit_crit_save_return_addr = paddr == off_crit_save_return_addr;
	wire logic hit_crit_save_machine_state = paddr == off_crit_save_machine_state;
	wire logic hit_esr = paddr == off_exception_syndrome;
	wire logic hit_machine_check_syndrome = paddr == off_machine_check_syndrome;
	wire logic hit_data_fault_address = paddr == off_data_fault_address;
	wire logic hit_handler = paddr == off_handler_addr;
	wire logic hit_any = hit_tsr | hit_tcr | hit_msr | hit_vector_prefix | hit_hid | hit_save_return_addr |
		hit_save_machine_state | hit_crit_save_return_addr | hit_crit_save_machine_state | hit_esr | hit_machine_check_syndrome | hit_data_fault_address | hit_handler |
		in_offset_bank;

	// timer status sources
	wire logic [5:0] fit_select = timer_control[tcr_fit_select_lsb +: 6];
	wire logic fit_bit = time_base[fit_select];
	wire logic fit_rise = fit_bit & ~fit_bit_prev;
	wire logic wdt_first = watchdog_timeout & ~watchdog_fired;

	// enabling conditions
	wire logic ee = machine_state_reg[msr_external_enable];
	wire logic ce = machine_state_reg[msr_critical_enable];
	wire logic req_float = pipe_event.float_instr & ~machine_state_reg[msr_float_available];
	wire logic req_sc = pipe_event.syscall_instr;
	wire logic req_dec = timer_status[tsr_decrementer_status] &
		timer_control[tcr_decrementer_int_enable] & ee;
	wire logic req_fit = timer_status[tsr_fixed_interval_status] &
		timer_control[tcr_fixed_interval_int_enable] & ee;
	wire logic req_wdt = timer_status[tsr_watchdog_status] &
		timer_control[tcr_watchdog_int_enable] & ce;
	wire logic req_dtlb = pipe_event.data_tlb_miss;
	wire logic req_itlb = pipe_event.instr_tlb_miss;
	// auxiliary slot has no request source at all
	wire logic req_aux = 1'b0;
	wire logic any_req = req_float | req_sc | req_dec | req_fit | req_wdt | req_dtlb |
		req_itlb | req_aux;
	// a register write in the same cycle is ignored by entry so there is one writer order
	wire logic take = any_req & ~higher_pending & clk_en;

	// fixed local order only breaks ties; true class priority comes through higher_pending
	cause_t next_cause;
	always_comb begin
		if (req_itlb) begin
			next_cause = cause_instr_tlb;
		end else if (req_float) begin
			next_cause = cause_float_unavail;
		end else if (req_sc) begin
			next_cause = cause_syscall;
		end else if (req_dtlb) begin
			next_cause = cause_data_tlb;
		end else if (req_wdt) begin
			next_cause = cause_watchdog;
		end else if (req_dec) begin
			next_cause = cause_decrementer;
		end else begin
			next_cause = cause_fixed_interval;
		end
	end

	wire logic is_crit = next_cause == cause_watchdog;
	wire logic [31:0] chosen_offset = vector_offset[next_cause];
	wire logic [31:0] next_handler = {vector_prefix[31:16], chosen_offset[15:4],
		vector_low_zero};

	// return address per cause
	logic [31:0] next_return;
	always_comb begin
		unique case (next_cause)
			cause_syscall: next_return = pipe_event.next_addr;
			cause_decrementer, cause_fixed_interval, cause_watchdog:
				next_return = pipe_event.next_addr;
			cause_data_tlb: next_return = pipe_event.instr_addr;
			cause_instr_tlb: next_return = pipe_event.instr_addr;
			default: next_return = pipe_event.instr_addr;
		endcase
	end

	// machine-state clearing mask
	localparam logic [31:0] noncrit_clear = (32'h1 << msr_user_cache_lock_enable) |
		(32'h1 << msr_vector_unit_enable) | (32'h1 << msr_wait) |
		(32'h1 << msr_external_enable) | (32'h1 << msr_problem_state) |
		(32'h1 << msr_float_available) | (32'h1 << msr_float_mode_bit0) |
		(32'h1 << msr_float_mode_bit1) | (32'h1 << msr_instruction_space) |
		(32'h1 << msr_data_space) | (32'h1 << msr_perf_mark);
	wire logic debug_unit_on = impl_config_reg[hid_debug_unit_enable];
	wire logic clear_de = ~debug_unit_on | impl_config_reg[hid_crit_clear_debug_enable];
	wire logic [31:0] crit_clear = noncrit_clear | (32'h1 << msr_critical_enable) |
		({31'h0, clear_de} << msr_debug_enable);
	wire logic [31:0] next_msr_entry = machine_state_reg & ~(is_crit ? crit_clear : noncrit_clear);

	// syndrome per cause; unchanged causes keep the old value
	logic [31:0] next_esr;
	always_comb begin
		next_esr = exception_syndrome;
		unique case (next_cause)
			cause_syscall: begin
				next_esr = reset_word;
				next_esr[esr_varlen_instr_flag] = pipe_event.varlen_instr;
			end
			cause_data_tlb: begin
				next_esr = reset_word;
				next_esr[esr_store_flag] = pipe_event.store_access;
				next_esr[esr_vector_flag] = pipe_event.vector_access;
				next_esr[esr_varlen_instr_flag] = pipe_event.varlen_instr;
			end
			cause_instr_tlb: begin
				next_esr = reset_word;
				next_esr[esr_misaligned_fetch_flag] = pipe_event.misaligned_fetch;
			end
			default: next_esr = exception_syndrome;
		endcase
	end

	// status: hardware set wins over software write-one-to-clear
	wire logic [31:0] tsr_set = ({31'h0, wdt_first} << tsr_watchdog_status) |
		({31'h0, decrementer_expired} << tsr_decrementer_status) |
		({31'h0, fit_rise} << tsr_fixed_interval_status);
	wire logic [31:0] tsr_clear = (wr_access & hit_tsr) ? (pwdata & wmask) : reset_word;
	wire logic [31:0] next_timer_status = (timer_status & ~tsr_clear) | tsr_set;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_status <= reset_word;
			fit_bit_prev <= 1'b0;
			watchdog_fired <= 1'b0;
		end else if (clk_en) begin
			timer_status <= next_timer_status;
			fit_bit_prev <= fit_bit;
			watchdog_fired <= watchdog_fired | watchdog_timeout;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			save_return_addr <= reset_word;
			save_machine_state <= reset_word;
			crit_save_return_addr <= reset_word;
			crit_save_machine_state <= reset_word;
			machine_state_reg <= reset_word;
			exception_syndrome <= reset_word;
			data_fault_address <= reset_word;
		end else if (take) begin
			machine_state_reg <= next_msr_entry;
			exception_syndrome <= next_esr;
			if (is_crit) begin
				crit_save_return_addr <= next_return;
				crit_save_machine_state <= machine_state_reg;
			end else begin
				save_return_addr <= next_return;
				save_machine_state <= machine_state_reg;
			end
			if (next_cause == cause_data_tlb) begin
				data_fault_address <= pipe_event.data_addr;
			end
		end else if (wr_access) begin
			if (hit_msr) machine_state_reg <= (machine_state_reg & ~wmask) | (pwdata & wmask);
			if (hit_save_return_addr) save_return_addr <= (save_return_addr & ~wmask) | (pwdata & wmask);
			if (hit_save_machine_state) save_machine_state <= (save_machine_state & ~wmask) | (pwdata & wmask);
			if (hit_crit_save_return_addr) crit_save_return_addr <= (crit_save_return_addr & ~wmask) | (pwdata & wmask);
			if (hit_crit_save_machine_state) crit_save_machine_state <= (crit_save_machine_state & ~wmask) | (pwdata & wmask);
			if (hit_esr) exception_syndrome <= (exception_syndrome & ~wmask) | (pwdata & wmask);
			if (hit_data_fault_address) data_fault_address <= (data_fault_address & ~wmask) | (pwdata & wmask);
		end
	end

	// configuration registers, software only; machine-check syndrome is never touched by entry
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_control <= reset_word;
			vector_prefix <= reset_word;
			impl_config_reg <= reset_word;
			machine_check_syndrome <= reset_word;
			for (int i = 0; i < num_offsets; i++) begin
				vector_offset[i] <= reset_word;
			end
		end else if (wr_access) begin
			if (hit_tcr) timer_control <= (timer_control & ~wmask) | (pwdata & wmask);
			if (hit_vector_prefix) vector_prefix <= (vector_prefix & ~wmask) | (pwdata & wmask);
			if (hit_hid) impl_config_reg <= (impl_config_reg & ~wmask) | (pwdata & wmask);
			if (hit_machine_check_syndrome) machine_check_syndrome <= (machine_check_syndrome & ~wmask) | (pwdata & wmask);
			// auxiliary slot offset exists but is never used for a vector
			if (in_offset_bank && offset_index != slot_aux_unavail) begin
				vector_offset[offset_index] <= (vector_offset[offset_index] & ~wmask) |
					(pwdata & wmask);
			end
		end
	end

	// entry report and read data registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			entry <= '0;
		end else if (clk_en) begin
			entry.taken <= take;
			entry.critical <= take & is_crit;
			entry.cause <= take ? next_cause : entry.cause;
			entry.handler <= take ? next_handler : entry.handler;
		end
	end

	logic [31:0] next_rdata;
	always_comb begin
		next_rdata = reset_word;
		if (in_offset_bank) next_rdata = vector_offset[offset_index];
		if (hit_save_return_addr) next_rdata = save_return_addr;
		if (hit_save_machine_state) next_rdata = save_machine_state;
		if (hit_crit_save_return_addr) next_rdata = crit_save_return_addr;
		if (hit_crit_save_machine_state) next_rdata = crit_save_machine_state;
		if (hit_msr) next_rdata = machine_state_reg;
		if (hit_esr) next_rdata = exception_syndrome;
		if (hit_machine_check_syndrome) next_rdata = machine_check_syndrome;
		if (hit_data_fault_address) next_rdata = data_fault_address;
		if (hit_vector_prefix) next_rdata = vector_prefix;
		if (hit_tsr) next_rdata = timer_status;
		if (hit_tcr) next_rdata = timer_control;
		if (hit_hid) next_rdata = impl_config_reg;
		if (hit_handler) next_rdata = entry.handler;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= reset_word;
		end else if (clk_en && psel && !penable) begin
			prdata <= next_rdata;
		end
	end

	// zero-wait slave; stalls with the clock enable
	assign pready = clk_en;
	assign pslverr = psel & penable & ~(hit_any & rd_valid);
endmodule

// ---- verilog/exc_entry_pkg.sv ----
// Purpose: shared constants and carriers for the exception-entry sequencer
// Assumes: 32-bit little-endian bit numbering (bit 0 is the lsb) in field positions
// Notes: offsets are word-aligned byte addresses on the register bus
package exc_entry_pkg;
	// register offsets
	localparam logic [11:0] off_save_return_addr = 12'h000;
	localparam logic [11:0] off_save_machine_state = 12'h004;
	localparam logic [11:0] off_crit_save_return_addr = 12'h008;
	localparam logic [11:0] off_crit_save_machine_state = 12'h00c;
	localparam logic [11:0] off_machine_state_reg = 12'h010;
	localparam logic [11:0] off_exception_syndrome = 12'h014;
	localparam logic [11:0] off_machine_check_syndrome = 12'h018;
	localparam logic [11:0] off_data_fault_address = 12'h01c;
	localparam logic [11:0] off_vector_prefix = 12'h020;
	localparam logic [11:0] off_timer_status = 12'h024;
	localparam logic [11:0] off_timer_control = 12'h028;
	localparam logic [11:0] off_impl_config_reg = 12'h02c;
	localparam logic [11:0] off_handler_addr = 12'h030;
	localparam logic [11:0] off_vector_offset_base = 12'h040;
	// machine state bit positions (lsb numbering)
	localparam int msr_user_cache_lock_enable = 26;
	localparam int msr_vector_unit_enable = 25;
	localparam int msr_wait = 18;
	localparam int msr_critical_enable = 17;
	localparam int msr_external_enable = 15;
	localparam int msr_problem_state = 14;
	localparam int msr_float_available = 13;
	localparam int msr_machine_check_enable = 12;
	localparam int msr_float_mode_bit0 = 11;
	localparam int msr_debug_enable = 9;
	localparam int msr_float_mode_bit1 = 8;
	localparam int msr_instruction_space = 5;
	localparam int msr_data_space = 4;
	localparam int msr_perf_mark = 2;
	localparam int msr_recoverable_flag = 1;
	// syndrome bit positions
	localparam int esr_store_flag = 23;
	localparam int esr_vector_flag = 7;
	localparam int esr_varlen_instr_flag = 5;
	localparam int esr_misaligned_fetch_flag = 1;
	// timer status / control and implementation config bit positions
	localparam int tsr_watchdog_status = 30;
	localparam int tsr_decrementer_status = 27;
	localparam int tsr_fixed_interval_status = 26;
	localparam int tcr_watchdog_int_enable = 27;
	localparam int tcr_decrementer_int_enable = 26;
	localparam int tcr_fixed_interval_int_enable = 23;
	localparam int tcr_fit_select_lsb = 0;
	localparam int hid_crit_clear_debug_enable = 17;
	localparam int hid_debug_unit_enable = 14;
	// reset value and vector constants
	localparam logic [31:0] reset_word = 32'h0000_0000;
	localparam logic [3:0] vector_low_zero = 4'h0;
	localparam int num_offsets = 8;
	localparam logic [2:0] slot_aux_unavail = 3'h2;

	typedef enum logic [2:0] {
		cause_float_unavail,
		cause_syscall,
		cause_aux_unavail,
		cause_decrementer,
		cause_fixed_interval,
		cause_watchdog,
		cause_data_tlb,
		cause_instr_tlb
	} cause_t;

	typedef struct packed {
		logic float_instr;
		logic syscall_instr;
		logic data_tlb_miss;
		logic instr_tlb_miss;
		logic store_access;
		logic vector_access;
		logic varlen_instr;
		logic misaligned_fetch;
		logic [31:0] instr_addr;
		logic [31:0] next_addr;
		logic [31:0] data_addr;
	} pipe_event_t;

	typedef struct packed {
		logic taken;
		logic critical;
		cause_t cause;
		logic [31:0] handler;
	} entry_report_t;
endpackage

// ---- bench/exc_entry_seq_monitor.sv ----
// Purpose: concurrent checks on the exception-entry sequencer ports
// Assumes: clk_en stays high while an entry is in flight
// Notes: machine state is not visible here, so enable conditions are checked in the bench
`timescale 1ns/1ps
module exc_entry_seq_monitor
	import exc_entry_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic higher_pending,
	input wire pipe_event_t pipe_event,
	input wire entry_report_t entry
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	property p_defer;
		clk_en && higher_pending |=> !entry.taken;
	endproperty
	a_defer: assert property (p_defer)
		else $error("entry taken while a higher exception was present");

	property p_float;
		entry.taken && entry.cause == cause_float_unavail |-> $past(pipe_event.float_instr);
	endproperty
	a_float: assert property (p_float)
		else $error("float unavailable entry without a float instruction");

	property p_aux;
		entry.taken |-> entry.cause != cause_aux_unavail;
	endproperty
	a_aux: assert property (p_aux)
		else $error("auxiliary unavailable slot raised");

	property p_sys;
		entry.taken && entry.cause == cause_syscall |-> $past(pipe_event.syscall_instr);
	endproperty
	a_sys: assert property (p_sys)
		else $error("system call entry without a system call");

	property p_dtlb;
		entry.taken && entry.cause == cause_data_tlb |-> $past(pipe_event.data_tlb_miss);
	endproperty
	a_dtlb: assert property (p_dtlb)
		else $error("data tlb entry without a data miss");

	property p_itlb;
		clk_en && !higher_pending && pipe_event.instr_tlb_miss
			|=> entry.taken && entry.cause == cause_instr_tlb;
	endproperty
	a_itlb: assert property (p_itlb)
		else $error("instruction tlb miss not entered next cycle");

	property p_vec;
		entry.taken |-> entry.handler[3:0] == 4'h0;
	endproperty
	a_vec: assert property (p_vec)
		else $error("handler address low nibble not zero");

	property p_crit;
		entry.taken |-> entry.critical == (entry.cause == cause_watchdog);
	endproperty
	a_crit: assert property (p_crit)
		else $error("critical flag does not match the watchdog cause");
endmodule

// ---- bench/tb.sv ----
// Purpose: self-checking bench for the exception-entry sequencer
// Assumes: apb answers with no wait states while clk_en is high
// Notes: timer status bits are set through the time base, time-out and decrementer pins
`timescale 1ns/1ps
module tb;
	import exc_entry_pkg::*;
	logic pclk = 0;
	logic presetn = 0;
	logic clk_en = 1;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [3:0] pstrb = 4'hf;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	pipe_event_t pipe_event = '0;
	logic higher_pending = 0;
	logic [63:0] time_base = '0;
	logic watchdog_timeout = 0;
	logic decrementer_expired = 0;
	entry_report_t entry;
	int fails = 0;
	int checks_done = 0;
	int cyc = 0;
	logic [31:0] m [0:11];
	logic [31:0] iv [0:7];
	logic [31:0] rd;
	logic err;
	pipe_event_t pe;
	always #2 pclk = ~pclk;
	exc_entry_seq dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .pipe_event(pipe_event),
		.higher_pending(higher_pending), .time_base(time_base),
		.watchdog_timeout(watchdog_timeout), .decrementer_expired(decrementer_expired),
		.entry(entry));
	task automatic final_report();
		if (fails == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		// one idle edge first, so psel is never assigned twice in one step
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// wait for an entry and compare the report, then the eight registers from offset 0 through data fault address
	task automatic fire(input cause_t c, input logic crit);
		int n;
		logic [31:0] old, mask, e;
		n = 0;
		pipe_event <= pe;
		@(posedge pclk);
		pipe_event[103:96] <= 8'h00;
		while (entry.taken !== 1'b1 && n < 40) begin
			@(posedge pclk);
			n++;
		end
		chk({31'h0, entry.taken}, 32'h1, "taken");
		chk(32'(entry.cause), 32'(c), "cause");
		chk({31'h0, entry.critical}, {31'h0, crit}, "critical");
		chk(entry.handler, {m[8][31:16], iv[c][15:4], 4'h0}, "handler");
		old = m[4];
		mask = 32'h0604_e934;
		e = '0;
		if (crit) begin
			mask[msr_critical_enable] = 1'b1;
			if (!m[11][hid_debug_unit_enable] || m[11][hid_crit_clear_debug_enable])
				mask[msr_debug_enable] = 1'b1;
			m[2] = pe.next_addr;
			m[3] = old;
		end else begin
			m[0] = (c == cause_syscall || c == cause_fixed_interval ||
				c == cause_decrementer) ? pe.next_addr : pe.instr_addr;
			m[1] = old;
		end
		m[4] = old & ~mask;
		e[esr_varlen_instr_flag] = pe.varlen_instr;
		e[esr_store_flag] = pe.store_access && c == cause_data_tlb;
		e[esr_vector_flag] = pe.vector_access && c == cause_data_tlb;
		if (c == cause_syscall || c == cause_data_tlb)
			m[5] = e;
		if (c == cause_instr_tlb)
			m[5] = {30'h0, pe.misaligned_fetch, 1'b0};
		if (c == cause_data_tlb)
			m[7] = pe.data_addr;
		for (int i = 0; i < 8; i++) begin
			apb(0, 12'(i * 4), '0);
			chk(rd, m[i], "state");
		end
	endtask
	// an event that must not be entered
	task automatic quiet();
		pipe_event <= pe;
		@(posedge pclk);
		pipe_event[103:96] <= 8'h00;
		repeat (4) begin
			@(posedge pclk);
			chk({31'h0, entry.taken}, 32'h0, "no entry");
		end
	endtask
	task automatic rnd_pe();
		pe = '0;
		pe[103:96] = 8'(($urandom % 16));
		pe.instr_addr = $urandom;
		pe.next_addr = pe.instr_addr + 32'h4;
		pe.data_addr = $urandom;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1, a, d);
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			fails++;
			final_report();
		end
	end
	initial begin
		void'($urandom(32'h6ae8519d));
		for (int i = 0; i < 12; i++)
			m[i] = '0;
		repeat (10) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		for (int i = 0; i < 12; i++) begin
			apb(0, 12'(i * 4), '0);
			chk(rd, m[i], "reset value");
		end
		m[8] = $urandom;
		wr(off_vector_prefix, m[8]);
		for (int i = 0; i < 8; i++) begin
			iv[i] = $urandom;
			wr(off_vector_offset_base + 12'(i * 4), iv[i]);
		end
		apb(0, 12'h048, '0);
		chk(rd, 32'h0, "aux offset");
		apb(0, 12'h034, '0);
		chk({31'h0, err}, 32'h1, "unmapped error");
		m[4] = ($urandom & 32'h0606_fb36) | 32'h0000_2000;
		wr(off_machine_state_reg, m[4]);
		rnd_pe();
		pe.float_instr = 1;
		quiet();
		m[4][msr_float_available] = 1'b0;
		wr(off_machine_state_reg, m[4]);
		fire(cause_float_unavail, 0);
		rnd_pe();
		pe.instr_tlb_miss = 1;
		higher_pending <= 1;
		quiet();
		higher_pending <= 0;
		fire(cause_instr_tlb, 0);
		rnd_pe();
		pe.syscall_instr = 1;
		clk_en <= 0;
		quiet();
		clk_en <= 1;
		fire(cause_syscall, 0);
		rnd_pe();
		pe.data_tlb_miss = 1;
		fire(cause_data_tlb, 0);
		m[10] = 32'(1 << tcr_fixed_interval_int_enable) | 32'($urandom % 64);
		wr(off_timer_control, m[10]);
		m[4] = ($urandom & 32'h0606_fb36) | 32'h0000_8000;
		wr(off_machine_state_reg, m[4]);
		rnd_pe();
		pe[103:96] = 8'h00;
		time_base[m[10][5:0]] <= 1'b1;
		fire(cause_fixed_interval, 0);
		m[9][tsr_fixed_interval_status] = 1'b1;
		apb(0, off_timer_status, '0);
		chk(rd, m[9], "fit status");
		wr(off_timer_status, m[9]);
		m[9] = '0;
		apb(0, off_timer_status, '0);
		chk(rd, m[9], "status cleared");
		m[10] = 32'(1 << tcr_decrementer_int_enable);
		wr(off_timer_control, m[10]);
		m[4] = ($urandom & 32'h0606_fb36) | 32'h0000_8000;
		wr(off_machine_state_reg, m[4]);
		rnd_pe();
		pe[103:96] = 8'h00;
		decrementer_expired <= 1;
		fire(cause_decrementer, 0);
		decrementer_expired <= 0;
		wr(off_timer_status, 32'(1 << tsr_decrementer_status));
		apb(0, off_timer_status, '0);
		chk(rd, m[9], "decrementer status cleared");
		m[10] = 32'(1 << tcr_watchdog_int_enable);
		wr(off_timer_control, m[10]);
		m[11] = $urandom & 32'h0002_4000;
		wr(off_impl_config_reg, m[11]);
		m[4] = ($urandom & 32'h0606_fb36) | 32'h0002_0000;
		wr(off_machine_state_reg, m[4]);
		rnd_pe();
		pe[103:96] = 8'h00;
		watchdog_timeout <= 1;
		fire(cause_watchdog, 1);
		watchdog_timeout <= 0;
		m[9][tsr_watchdog_status] = 1'b1;
		apb(0, off_timer_status, '0);
		chk(rd, m[9], "watchdog status");
		final_report();
	end
endmodule
bind exc_entry_seq exc_entry_seq_monitor mon (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
	.higher_pending(higher_pending), .pipe_event(pipe_event), .entry(entry));
